// *** verilog/eid_pkg.sv ***
package eid_pkg;

   // Instruction word and data widths.
   localparam int EID_IW = 14;
   localparam int EID_DW = 8;
   localparam int EID_PW = 16;

   // Fixed encodings of the single-word instructions.
   localparam logic [13:0] EID_OP_BRANCH_ACC = 14'h000B;
   localparam logic [13:0] EID_OP_CALL_ACC = 14'h000A;
   localparam logic [13:0] EID_OP_PRESCALE = 14'h0062;
   localparam logic [13:0] EID_OP_STANDBY = 14'h0063;
   localparam logic [13:0] EID_OP_KICK = 14'h0064;
   localparam logic [13:0] EID_OP_IDLE = 14'h0000;

   // Masked encodings: value compared after the mask is applied.
   localparam logic [13:0] EID_MSK_RETLIT = 14'h3F00;
   localparam logic [13:0] EID_VAL_RETLIT = 14'h3400;
   localparam logic [13:0] EID_MSK_DIR = 14'h3FF8;
   localparam logic [13:0] EID_VAL_DIR = 14'h0060;
   localparam logic [13:0] EID_MSK_PADD = 14'h3F80;
   localparam logic [13:0] EID_VAL_PADD = 14'h3100;
   localparam logic [13:0] EID_MSK_REL = 14'h3E00;
   localparam logic [13:0] EID_VAL_REL = 14'h3200;
   localparam logic [13:0] EID_MSK_ILD = 14'h3FF8;
   localparam logic [13:0] EID_VAL_ILD = 14'h0010;
   localparam logic [13:0] EID_MSK_IST = 14'h3FF8;
   localparam logic [13:0] EID_VAL_IST = 14'h0018;
   localparam logic [13:0] EID_MSK_XLD = 14'h3F80;
   localparam logic [13:0] EID_VAL_XLD = 14'h3F00;
   localparam logic [13:0] EID_MSK_XST = 14'h3F80;
   localparam logic [13:0] EID_VAL_XST = 14'h3F80;

   // Field positions.
   localparam int EID_POS_PSEL_SHORT = 2;
   localparam int EID_POS_PSEL_LONG = 6;
   localparam int EID_POS_PTR_MSB = 15;

   // Reset values of the status flags.
   localparam logic EID_RST_TIMEOUT = 1'b1;
   localparam logic EID_RST_POWERDOWN = 1'b1;

   // Cycle counts.
   localparam logic [1:0] EID_CYC_ONE = 2'h1;
   localparam logic [1:0] EID_CYC_TWO = 2'h2;

   // Pointer modifier codes.
   typedef enum logic [1:0] {
      EID_MOD_PREINC = 2'h0,
      EID_MOD_PREDEC = 2'h1,
      EID_MOD_POSTINC = 2'h2,
      EID_MOD_POSTDEC = 2'h3
   } eid_mod_type;

   // Operation class of the decoded word.
   typedef enum logic [3:0] {
      EID_K_IDLE,
      EID_K_BRANCH_ACC,
      EID_K_CALL_ACC,
      EID_K_RETLIT,
      EID_K_PRESCALE,
      EID_K_DIRLOAD,
      EID_K_STANDBY,
      EID_K_KICK,
      EID_K_PADD,
      EID_K_ILOAD,
      EID_K_ISTORE,
      EID_K_XLOAD,
      EID_K_XSTORE,
      EID_K_RELJUMP,
      EID_K_OTHER
   } eid_kind_type;

   // Decoded instruction fields.
   typedef struct packed {
      eid_kind_type kind;
      logic ptr_sel;
      eid_mod_type modif;
      logic [5:0] lit6;
      logic [7:0] lit8;
      logic [2:0] dir_sel;
      logic [8:0] rel_off;
      logic pc_change;
   } eid_dec_type;

   // Memory access request toward data memory.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } eid_mem_type;

endpackage

// *** verilog/eid_field_decode.sv ***
`timescale 1ns/1ps

// Pure combinational split of one instruction word into its class and fields.
module eid_field_decode
   import eid_pkg::*;
(
   // Instruction word.
   input wire logic [13:0] word,
   // Decoded result.
   output eid_pkg::eid_dec_type dec
);

   // The order of tests matters: exact codes first, then masked groups.
   always_comb
   begin
      dec = '0;
      dec.lit8 = word[7:0];
      dec.lit6 = word[5:0];
      dec.dir_sel = word[2:0];
      dec.rel_off = word[8:0];
      dec.modif = eid_mod_type'(word[1:0]);
      dec.ptr_sel = word[EID_POS_PSEL_SHORT];
      if (word == EID_OP_IDLE)
      begin
         dec.kind = EID_K_IDLE;
      end
      else if (word == EID_OP_BRANCH_ACC)
      begin
         dec.kind = EID_K_BRANCH_ACC; // RQ1
         dec.pc_change = 1'b1;
      end
      else if (word == EID_OP_CALL_ACC)
      begin
         dec.kind = EID_K_CALL_ACC; // RQ2
         dec.pc_change = 1'b1;
      end
      else if (word == EID_OP_PRESCALE)
      begin
         dec.kind = EID_K_PRESCALE; // RQ4
      end
      else if (word == EID_OP_STANDBY)
      begin
         dec.kind = EID_K_STANDBY; // RQ6
      end
      else if (word == EID_OP_KICK)
      begin
         dec.kind = EID_K_KICK; // RQ16
      end
      else if ((word & EID_MSK_DIR) == EID_VAL_DIR)
      begin
         dec.kind = EID_K_DIRLOAD; // RQ5
      end
      else if ((word & EID_MSK_RETLIT) == EID_VAL_RETLIT)
      begin
         dec.kind = EID_K_RETLIT; // RQ3
         dec.pc_change = 1'b1;
      end
      else if ((word & EID_MSK_REL) == EID_VAL_REL)
      begin
         dec.kind = EID_K_RELJUMP; // RQ15
         dec.pc_change = 1'b1;
      end
      else if ((word & EID_MSK_PADD) == EID_VAL_PADD)
      begin
         dec.kind = EID_K_PADD; // RQ7
         dec.ptr_sel = word[EID_POS_PSEL_LONG];
      end
      else if ((word & EID_MSK_ILD) == EID_VAL_ILD)
      begin
         dec.kind = EID_K_ILOAD; // RQ8
      end
      else if ((word & EID_MSK_IST) == EID_VAL_IST)
      begin
         dec.kind = EID_K_ISTORE; // RQ11
      end
      else if ((word & EID_MSK_XLD) == EID_VAL_XLD)
      begin
         dec.kind = EID_K_XLOAD; // RQ9
         dec.ptr_sel = word[EID_POS_PSEL_LONG];
      end
      else if ((word & EID_MSK_XST) == EID_VAL_XST)
      begin
         dec.kind = EID_K_XSTORE; // RQ10
         dec.ptr_sel = word[EID_POS_PSEL_LONG];
      end
      else
      begin
         dec.kind = EID_K_OTHER;
      end
   end

endmodule // eid_field_decode

// *** verilog/eid_decoder.sv ***
`timescale 1ns/1ps

// Behaviour
// (RQ1) Decode branch by accumulator, two cycles.
// (RQ2) Decode call by accumulator, two cycles.
// (RQ3) Return loading literal into accumulator, two cycles.
// (RQ4) Copy accumulator to prescaler config, one cycle.
// (RQ5) Copy accumulator to selected direction register.
// (RQ6) Standby entry updates timeout and powerdown flags.
// (RQ7) Add six-bit literal to selected pointer.
// (RQ8) Pointer load with pre/post modifier, sets zero.
// (RQ9) Indexed indirect load updates zero flag.
// (RQ10) Indexed indirect store, flags unchanged.
// (RQ11) Pointer store with modifier, flags unchanged.
// (RQ12) Program counter change costs two cycles.
// (RQ13) Second cycle is an idle slot.
// (RQ14) Extra cycle when pointer top bit set.
// (RQ15) Relative jump: signed nine-bit offset, two cycles.
// (RQ16) Watchdog kick sets timeout and powerdown flags.
module eid_decoder
   import eid_pkg::*;
#(
   parameter int DIR_REGS = 8
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Instruction fetch from program memory.
   input wire logic [13:0] instr_word,
   input wire logic instr_valid,
   output logic instr_ready,
   // Data memory read answer, taken in the accept cycle, one cycle before the registered read request shows.
   input wire logic [7:0] mem_rdata,
   // Data memory request.
   output eid_pkg::eid_mem_type mem_req,
   // Architectural state views.
   output logic [15:0] pc,
   output logic [7:0] accum,
   output logic [7:0] prescale_cfg,
   output logic [7:0] dir_reg [DIR_REGS],
   output logic [15:0] ptr0,
   output logic [15:0] ptr1,
   output logic zero_flag,
   output logic watchdog_timeout_flag,
   output logic powerdown_flag,
   output logic standby,
   // Pulses and the held cycle count for surrounding logic.
   output logic call_push,
   output logic ret_pop,
   output logic watchdog_kick,
   output logic [1:0] cycles_last
);
   import eid_pkg::*;

   // Decoded form of the incoming word.
   eid_dec_type dec;
   // Architectural registers.
   logic [15:0] pc_q, pc_d;
   logic [7:0] acc_q, acc_d;
   logic [7:0] pre_q, pre_d;
   logic [7:0] dir_q [DIR_REGS];
   logic [7:0] dir_d [DIR_REGS];
   logic [15:0] ptr_q [2];
   logic [15:0] ptr_d [2];
   logic z_q, z_d;
   logic tmo_q, tmo_d;
   logic down_q, down_d;
   logic sb_q, sb_d;
   // Number of idle slots still owed by the last instruction.
   logic [1:0] stall_q, stall_d;
   logic [1:0] cyc_q, cyc_d;
   // Output pulse registers.
   logic push_q, push_d;
   logic pop_q, pop_d;
   logic kick_q, kick_d;
   eid_mem_type mem_q, mem_d;
   // Pointer arithmetic helpers.
   logic [15:0] psel;
   logic [15:0] pmod;
   logic [15:0] paddr;
   logic [15:0] pidx;
   logic [15:0] pc_inc;
   logic go;

   eid_field_decode u_dec
   (
      .word(instr_word),
      .dec(dec)
   );

   // A word is accepted only when no idle slot is pending.
   assign instr_ready = (stall_q == 2'h0);
   // The word is consumed only on the edge where both sides agree.
   assign go = instr_valid && instr_ready;
   assign psel = ptr_q[dec.ptr_sel];
   assign pc_inc = pc_q + 16'h0001;
   // Pre modes use the modified value as the address, post modes the old one.
   assign pmod = dec.modif[0] ? (psel - 16'h0001) : (psel + 16'h0001);
   assign paddr = dec.modif[1] ? psel : pmod;
   // Indexed form treats the six-bit literal as signed.
   assign pidx = psel + {{10{dec.lit6[5]}}, dec.lit6};

   // Next state of the whole instruction engine.
   always_comb
   begin
      pc_d = pc_q;
      acc_d = acc_q;
      pre_d = pre_q;
      dir_d = dir_q;
      ptr_d = ptr_q;
      z_d = z_q;
      tmo_d = tmo_q;
      down_d = down_q;
      sb_d = sb_q;
      stall_d = stall_q;
      cyc_d = cyc_q;
      push_d = 1'b0;
      pop_d = 1'b0;
      kick_d = 1'b0;
      mem_d = '0;
      if (stall_q != 2'h0)
      begin
         // Owed cycle: nothing architectural changes.
         stall_d = stall_q - 2'h1; // RQ13
      end
      else if (go)
      begin
         pc_d = pc_inc;
         cyc_d = EID_CYC_ONE;
         case (dec.kind)
            EID_K_BRANCH_ACC:
            begin
               // The accumulator is an unsigned step forward from the next word.
               pc_d = pc_inc + {8'h00, acc_q}; // RQ1
            end
            EID_K_CALL_ACC:
            begin
               // The upper page is kept; the return address leaves on the push pulse.
               pc_d = {pc_q[15:8], acc_q}; // RQ2
               push_d = 1'b1;
            end
            EID_K_RETLIT:
            begin
               // The return address lives in the external stack, so pc only steps here.
               acc_d = dec.lit8; // RQ3
               pop_d = 1'b1;
            end
            EID_K_RELJUMP:
            begin
               // The nine-bit field is signed, so short loops backward need no extra word.
               pc_d = pc_inc + {{7{dec.rel_off[8]}}, dec.rel_off}; // RQ15
            end
            EID_K_PRESCALE:
            begin
               // The copy is seen from the next cycle on; no flag moves.
               pre_d = acc_q; // RQ4
            end
            EID_K_DIRLOAD:
            begin
               // Selectors beyond the implemented set are ignored.
               if (32'(dec.dir_sel) < DIR_REGS)
               begin
                  dir_d[dec.dir_sel] = acc_q; // RQ5
               end
            end
            EID_K_STANDBY:
            begin
               // The cleared powerdown flag stays so until a kick or a reset.
               tmo_d = 1'b1; // RQ6
               down_d = 1'b0; // RQ6
               sb_d = 1'b1;
            end
            EID_K_KICK:
            begin
               // A kick returns both flags to their power-up state.
               tmo_d = 1'b1; // RQ16
               down_d = 1'b1; // RQ16
               kick_d = 1'b1;
            end
            EID_K_PADD:
            begin
               // The literal is unsigned here, unlike the indexed offset.
               ptr_d[dec.ptr_sel] = psel + {10'h000, dec.lit6}; // RQ7
            end
            EID_K_ILOAD:
            begin
               // Read data must stand in the accept cycle, as there is no wait state.
               ptr_d[dec.ptr_sel] = pmod; // RQ8
               mem_d.rd = 1'b1;
               mem_d.addr = paddr;
               acc_d = mem_rdata;
               z_d = (mem_rdata == 8'h00); // RQ8
            end
            EID_K_XLOAD:
            begin
               // The pointer itself is left as it was.
               mem_d.rd = 1'b1; // RQ9
               mem_d.addr = pidx;
               acc_d = mem_rdata;
               z_d = (mem_rdata == 8'h00); // RQ9
            end
            EID_K_ISTORE:
            begin
               // Stores never touch the zero flag.
               ptr_d[dec.ptr_sel] = pmod; // RQ11
               mem_d.wr = 1'b1;
               mem_d.addr = paddr;
               mem_d.wdata = acc_q;
            end
            EID_K_XSTORE:
            begin
               // Neither the pointer nor any flag changes.
               mem_d.wr = 1'b1; // RQ10
               mem_d.addr = pidx;
               mem_d.wdata = acc_q;
            end
            default:
            begin
               // Idle slot and unsupported words only advance the counter.
               pc_d = pc_inc;
            end
         endcase
         // Program counter changes take one extra idle cycle.
         if (dec.pc_change)
         begin
            stall_d = 2'h1; // RQ12
            cyc_d = EID_CYC_TWO; // RQ12
         end
         // An indirect access with the pointer top bit set costs one more cycle.
         if ((dec.kind == EID_K_ILOAD || dec.kind == EID_K_ISTORE ||
              dec.kind == EID_K_XLOAD || dec.kind == EID_K_XSTORE) && psel[EID_POS_PTR_MSB])
         begin
            stall_d = stall_d + 2'h1; // RQ14
            cyc_d = cyc_d + 2'h1; // RQ14
         end
      end
   end

   // Register stage; flags reset to their power-up values.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pc_q <= 16'h0000;
         acc_q <= 8'h00;
         // Configuration registers come up all ones, the safe input setting.
         pre_q <= 8'hFF;
         for (int i = 0; i < DIR_REGS; i++)
         begin
            dir_q[i] <= 8'hFF;
         end
         ptr_q[0] <= 16'h0000;
         ptr_q[1] <= 16'h0000;
         z_q <= 1'b0;
         tmo_q <= EID_RST_TIMEOUT;
         down_q <= EID_RST_POWERDOWN;
         sb_q <= 1'b0;
         stall_q <= 2'h0;
         cyc_q <= 2'h0;
         push_q <= 1'b0;
         pop_q <= 1'b0;
         kick_q <= 1'b0;
         mem_q <= '0;
      end
      else
      begin
         // Every register loads its next value on every edge.
         pc_q <= pc_d;
         acc_q <= acc_d;
         pre_q <= pre_d;
         dir_q <= dir_d;
         ptr_q <= ptr_d;
         z_q <= z_d;
         tmo_q <= tmo_d;
         down_q <= down_d;
         sb_q <= sb_d;
         stall_q <= stall_d;
         cyc_q <= cyc_d;
         push_q <= push_d;
         pop_q <= pop_d;
         kick_q <= kick_d;
         mem_q <= mem_d;
      end
   end

   // Registered views of the state.
   assign pc = pc_q;
   assign accum = acc_q;
   assign prescale_cfg = pre_q;
   assign dir_reg = dir_q;
   assign ptr0 = ptr_q[0];
   assign ptr1 = ptr_q[1];
   assign zero_flag = z_q;
   assign watchdog_timeout_flag = tmo_q;
   assign powerdown_flag = down_q;
   assign standby = sb_q;
   // Pulses last one cycle because their next values default to zero.
   assign call_push = push_q;
   assign ret_pop = pop_q;
   assign watchdog_kick = kick_q;
   assign cycles_last = cyc_q;
   assign mem_req = mem_q;

endmodule // eid_decoder

// *** verif/eid_decoder_monitor.sv ***
`timescale 1ns/1ps

// Watches the decoder's ports and ties nine of the decoded classes to their effect.
module eid_decoder_monitor
   import eid_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Fetch side.
   input wire logic [13:0] instr_word,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic [7:0] mem_rdata,
   // Results.
   input wire eid_pkg::eid_mem_type mem_req,
   input wire logic [15:0] pc,
   input wire logic [7:0] accum,
   input wire logic [7:0] prescale_cfg,
   input wire logic zero_flag,
   input wire logic watchdog_timeout_flag,
   input wire logic powerdown_flag,
   input wire logic standby,
   input wire logic call_push,
   input wire logic ret_pop,
   input wire logic watchdog_kick,
   input wire logic [1:0] cycles_last
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // A word counts only on the edge that takes it.
   wire tk = instr_valid && instr_ready;
   wire [13:0] w = instr_word;
   // Words that move the program counter owe one idle slot.
   wire jmp = w == EID_OP_BRANCH_ACC || w == EID_OP_CALL_ACC || (w & EID_MSK_RETLIT) == EID_VAL_RETLIT
      || (w & EID_MSK_REL) == EID_VAL_REL;

   a_branch_pc: assert property (
      tk && w == EID_OP_BRANCH_ACC |=> pc == $past(pc) + 16'h0001 + {8'h00, $past(accum)}
      && cycles_last == EID_CYC_TWO) else $error("branch target wrong");
   a_call_target: assert property (
      tk && w == EID_OP_CALL_ACC |=> call_push && pc == {$past(pc[15:8]), $past(accum)})
      else $error("call target wrong");
   a_ret_literal: assert property (
      tk && (w & EID_MSK_RETLIT) == EID_VAL_RETLIT |=> accum == $past(w[7:0]) && ret_pop)
      else $error("return literal not loaded");
   a_prescale_copy: assert property (
      tk && w == EID_OP_PRESCALE |=> prescale_cfg == $past(accum) && cycles_last == EID_CYC_ONE)
      else $error("prescale copy wrong");
   a_standby_flags: assert property (
      tk && w == EID_OP_STANDBY |=> standby && watchdog_timeout_flag && !powerdown_flag)
      else $error("standby flags wrong");
   a_kick_flags: assert property (
      tk && w == EID_OP_KICK |=> watchdog_kick && watchdog_timeout_flag && powerdown_flag)
      else $error("kick flags wrong");
   a_idle_slot: assert property (
      tk && jmp |=> !instr_ready ##1 (instr_ready && $stable(pc) && $stable(accum)))
      else $error("idle slot wrong");
   a_xstore_flags: assert property (
      tk && (w & EID_MSK_XST) == EID_VAL_XST |=> mem_req.wr && mem_req.wdata == $past(accum)
      && zero_flag == $past(zero_flag)) else $error("indexed store wrong");
   a_rel_jump: assert property (
      tk && (w & EID_MSK_REL) == EID_VAL_REL
      |=> pc == $past(pc) + 16'h0001 + {{7{$past(w[8])}}, $past(w[8:0])}) else $error("jump target wrong");
   a_load_zero: assert property (
      tk && (w & EID_MSK_ILD) == EID_VAL_ILD |=> accum == $past(mem_rdata)
      && zero_flag == ($past(mem_rdata) == 8'h00)) else $error("pointer load wrong");

   // Main scenarios seen.
   c_branch: cover property (tk && w == EID_OP_BRANCH_ACC);
   c_kick: cover property (tk && w == EID_OP_KICK);
   c_xstore: cover property (tk && (w & EID_MSK_XST) == EID_VAL_XST);
endmodule // eid_decoder_monitor

bind eid_decoder eid_decoder_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .instr_word(instr_word),
   .instr_valid(instr_valid), .instr_ready(instr_ready), .mem_rdata(mem_rdata), .mem_req(mem_req), .pc(pc),
   .accum(accum), .prescale_cfg(prescale_cfg), .zero_flag(zero_flag), .watchdog_timeout_flag(watchdog_timeout_flag),
   .powerdown_flag(powerdown_flag), .standby(standby), .call_push(call_push), .ret_pop(ret_pop),
   .watchdog_kick(watchdog_kick), .cycles_last(cycles_last));

// *** verif/eid_prog_mem.sv ***
`timescale 1ns/1ps

// Program memory stand-in: offers one word per request and holds it until taken.
module eid_prog_mem
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Request from the bench.
   input wire logic go,
   input wire logic [13:0] fw,
   // Fetch handshake.
   input wire logic instr_ready,
   output logic [13:0] instr_word = 14'h0000,
   output logic instr_valid = 1'b0,
   output logic took = 1'b0
);
   // Taken flag follows the decoder's own accept edge.
   always @(posedge clk_sys)
      took <= instr_valid && instr_ready && !rst;
   // An idle bus shows the inverse word, so stale data is never mistaken for a fetch.
   always @(negedge clk_sys)
      if (rst || (instr_valid && took))
      begin
         instr_valid <= 1'b0;
         instr_word <= ~instr_word;
      end
      else if (go && !instr_valid)
      begin
         instr_valid <= 1'b1;
         instr_word <= fw;
      end
endmodule // eid_prog_mem

// *** verif/eid_decoder_test.sv ***
`timescale 1ns/1ps

// Feeds words through the program memory stand-in and checks every result.
module eid_decoder_test;
   import eid_pkg::*;
   // Expected outcome of one word; a cycle count of zero is not judged.
   typedef struct packed {logic [15:0] pc; logic [7:0] acc; logic [1:0] cyc; logic [2:0] fl;
      logic rd; logic wr; logic [15:0] ad; logic [7:0] wd; logic [15:0] p0; logic [15:0] p1;} eid_exp_type;
   logic clk_sys = 1'b0, rst = 1'b1, go = 1'b0;
   logic [13:0] fw = 14'h0000;
   logic [7:0] mem_rdata = 8'h00;
   logic [13:0] instr_word;
   logic instr_valid, instr_ready, took;
   eid_mem_type mem_req;
   logic [15:0] pc, ptr0, ptr1, m_pc;
   logic [15:0] m_p [2];
   logic [7:0] accum, prescale_cfg, m_acc, m_pre;
   logic [7:0] dir_reg [8];
   logic [7:0] m_dir [8];
   logic zero_flag, watchdog_timeout_flag, powerdown_flag, standby, m_z, m_down;
   logic [1:0] cycles_last;
   logic [3:0] u;
   int fail_count = 0, tests_run = 0;
   eid_exp_type q [$];
   eid_exp_type w_e, w_g;

   always #10 clk_sys = ~clk_sys;

   eid_prog_mem prog (.clk_sys(clk_sys), .rst(rst), .go(go), .fw(fw), .instr_ready(instr_ready),
      .instr_word(instr_word), .instr_valid(instr_valid), .took(took));
   eid_decoder dut (.clk_sys(clk_sys), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .mem_rdata(mem_rdata), .mem_req(mem_req), .pc(pc), .accum(accum),
      .prescale_cfg(prescale_cfg), .dir_reg(dir_reg), .ptr0(ptr0), .ptr1(ptr1), .zero_flag(zero_flag),
      .watchdog_timeout_flag(watchdog_timeout_flag), .powerdown_flag(powerdown_flag), .standby(standby),
      .call_push(), .ret_pop(), .watchdog_kick(), .cycles_last(cycles_last));

   task automatic bad(input string s);
      $display("[FAIL] t=%0t %s", $time, s);
      fail_count++;
   endtask

   task automatic cmp(input logic ok, input string s);
      tests_run++;
      if (ok !== 1'b1)
         bad(s);
   endtask

   task automatic close_out;
      $display("mismatches %0d, checks %0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Model state after reset; pc is taken to restart at zero.
   task automatic mreset;
      m_pc = 16'h0000;
      m_p = '{16'h0000, 16'h0000};
      m_acc = 8'h00;
      m_z = 1'b0;
      m_down = 1'b1;
      m_pre = 8'hFF;
      m_dir = '{default: 8'hFF};
   endtask

   // Compares the standing state against the model.
   task automatic rchk(input logic sb);
      cmp({prescale_cfg, ptr0, ptr1, zero_flag, watchdog_timeout_flag, powerdown_flag, standby}
         === {m_pre, m_p[0], m_p[1], m_z, 1'b1, m_down, sb}, "standing state");
      for (int i = 0; i < 8; i++)
         cmp(dir_reg[i] === m_dir[i], "direction register");
   endtask

   // Works out the outcome of one word, notes it, then offers the word.
   task automatic run(input logic [13:0] iw, input logic [7:0] rd);
      eid_exp_type e;
      logic [15:0] a, nw;
      logic n;
      int i;
      e = '0;
      n = iw[13] ? iw[6] : iw[2];
      a = m_pc;
      m_pc = m_pc + 16'h0001;
      e.cyc = (iw[13:1] == 13'h0005 || iw[13:8] == 6'h34 || iw[13:9] == 5'h19) ? 2'h2 : 2'h1;
      casez (iw)
         14'h000B: m_pc = m_pc + {8'h00, m_acc};
         14'h000A: m_pc = {a[15:8], m_acc};
         14'b11_0100_????_????: m_acc = iw[7:0];
         14'b11_001?_????_????: m_pc = m_pc + {{7{iw[8]}}, iw[8:0]};
         14'h0062: m_pre = m_acc;
         14'h0063: m_down = 1'b0;
         14'h0064: m_down = 1'b1;
         14'b00_0000_0110_0???: m_dir[iw[2:0]] = m_acc;
         14'b11_0001_0???_????: m_p[n] = m_p[n] + {10'h000, iw[5:0]};
         14'b00_0000_0001_????:
         begin
            a = m_p[n];
            nw = iw[0] ? a - 16'h0001 : a + 16'h0001;
            m_p[n] = nw;
            e.ad = iw[1] ? a : nw;
            e.cyc = (a[15] & nw[15]) ? 2'h2 : (a[15] | nw[15]) ? 2'h0 : 2'h1;
            e.rd = !iw[3];
            e.wr = iw[3];
         end
         14'b11_1111_????_????:
         begin
            e.ad = m_p[n] + {{10{iw[5]}}, iw[5:0]};
            e.cyc = m_p[n][15] ? 2'h2 : 2'h1;
            e.rd = !iw[7];
            e.wr = iw[7];
         end
         default: ;
      endcase
      if (e.rd)
      begin
         m_acc = rd;
         m_z = rd == 8'h00;
      end
      e.wd = e.wr ? m_acc : 8'h00;
      e.pc = m_pc;
      e.acc = m_acc;
      e.fl = {m_z, 1'b1, m_down};
      e.p0 = m_p[0];
      e.p1 = m_p[1];
      q.push_back(e);
      mem_rdata <= rd;
      fw <= iw;
      go <= 1'b1;
      @(negedge clk_sys);
      go <= 1'b0;
      for (i = 0; i < 20 && !took; i++)
         @(negedge clk_sys);
      if (!took)
      begin
         bad("word not taken");
         close_out;
      end
   endtask

   // Takes the oldest note whenever a word has been taken and compares.
   always @(negedge clk_sys)
      if (took)
      begin
         if (q.size() == 0)
            bad("result with no word");
         else
         begin
            w_e = q.pop_front();
            w_g = {pc, accum, cycles_last, zero_flag, watchdog_timeout_flag, powerdown_flag, mem_req.rd,
               mem_req.wr, mem_req.addr, mem_req.wdata, ptr0, ptr1};
            if (w_e.cyc == 2'h0)
               w_g.cyc = 2'h0;
            if (!(w_e.rd | w_e.wr))
               w_g.ad = 16'h0000;
            if (!w_e.wr)
               w_g.wd = 8'h00;
            cmp(w_g === w_e, "decoded result differs");
         end
      end

   // Main sequence.
   initial
   begin
      void'($urandom(54));
      mreset;
      repeat (4) @(negedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      rchk(1'b0);
      for (u = 0; u < 8; u++)
      begin
         run({6'h34, 8'($urandom)}, 8'($urandom));
         run({11'h00C, u[2:0]}, 8'($urandom));
      end
      run(14'h3481, 8'($urandom));
      run(14'h0062, 8'($urandom));
      run(14'h000B, 8'($urandom));
      run(14'h000A, 8'($urandom));
      run(14'h0000, 8'($urandom));
      run(14'h33FE, 8'($urandom));
      run(14'h3205, 8'($urandom));
      run(14'h317F, 8'($urandom));
      for (u = 0; u < 8; u++)
         run({10'h001, u[2], 1'b1, u[1:0]}, 8'($urandom));
      run(14'h0011, 8'h00);
      run(14'h0013, 8'($urandom));
      run(14'h3F7E, 8'($urandom));
      run(14'h3FC5, 8'($urandom));
      run(14'h3F81, 8'($urandom));
      run(14'h0064, 8'($urandom));
      run(14'h0063, 8'($urandom));
      rchk(1'b1);
      rst <= 1'b1;
      repeat (2) @(negedge clk_sys);
      rst <= 1'b0;
      mreset;
      @(negedge clk_sys);
      rchk(1'b0);
      run(14'h34A5, 8'($urandom));
      run(14'h0064, 8'($urandom));
      repeat (2) @(negedge clk_sys);
      close_out;
   end
endmodule // eid_decoder_test
